// [rtl/ckgen_top.sv]
// clock generation and oscillator control, single-module implementation
// assumes oscillator pins are sampled synchronously to clock_in and that
// every derived clock is consumed as a one-cycle enable on clock_in
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps

module ckgen_top
    import ckgen_pkg::*;
#(
    parameter int PLL_LOCK_CYC = CKGEN_PLL_LOCK_CYC,
    parameter int TOGGLE_CYC   = CKGEN_TOGGLE_CYC
) (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // power management and external reset
    input  wire logic       stop_main_osc_in,
    input  wire logic       stop_slow_osc_in,
    input  wire logic       sys_suspend_in,
    input  wire logic       ext_reset_n_in,
    // oscillator pins
    input  wire logic       main_osc_in,
    output logic            main_osc_out,
    input  wire logic       slow_osc_in,
    output logic            slow_osc_out,
    // derived clock enables and status
    output logic            main_clk_en_out,
    output logic            slow_clk_en_out,
    output logic            pll_clk_en_out,
    output logic            sys_clk_en_out,
    output logic            aux1_clk_en_out,
    output logic            aux2_clk_en_out,
    output logic            main_good_out,
    output logic            slow_good_out,
    output logic            int_reset_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        main_prev;
        logic        slow_prev;
        logic [13:0] main_cnt;
        logic        main_half;
        logic [5:0]  slow_cnt;
        logic        pre_half;
        logic [7:0]  pre_cnt;
        logic [15:0] toggle_cnt;
        logic [15:0] lock_cnt;
        logic [7:0]  pll_acc;
        logic        high_freq_clock_select;
        logic [7:0]  ctrl;
        logic [7:0]  hfpre;
        logic [7:0]  slpre;
        logic [7:0]  auxpre;
        logic [3:0]  sys_cnt;
        logic [3:0]  aux1_cnt;
        logic [3:0]  aux2_cnt;
        logic        main_en;
        logic        slow_en;
        logic        pll_en;
        logic        sys_en;
        logic        aux1_en;
        logic        aux2_en;
        logic [7:0]  rdata;
    } ckgen_state_t;

    ckgen_state_t state_q;
    ckgen_state_t state_d;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // divide-by-(lim+1) on source ticks; returns {pulse, next count}
    function automatic logic [4:0] ckgen_div(input logic [3:0] cnt,
                                             input logic [3:0] lim,
                                             input logic       tick);
        return tick ? ((cnt >= lim) ? 5'h10 : {1'b0, cnt + 4'h1}) : {1'b0, cnt};
    endfunction : ckgen_div

    // pll multiplier code to main-clock-relative step
    function automatic logic [7:0] ckgen_mul(input logic [1:0] mode);
        logic [7:0] m;
        unique case (mode)
            CKGEN_MODE_X3: m = CKGEN_MUL3;
            CKGEN_MODE_X4: m = CKGEN_MUL4;
            default:       m = CKGEN_MUL5;
        endcase
        return m;
    endfunction : ckgen_mul

    localparam logic [15:0] LOCK_LAST   = 16'(PLL_LOCK_CYC - 1);
    localparam logic [15:0] TOGGLE_LAST = 16'(TOGGLE_CYC - 1);
    localparam logic [7:0]  MAIN_STEP   = 8'(CKGEN_MAIN_MHZ);
    localparam logic [7:0]  CLK_STEP    = 8'(CKGEN_CLK_MHZ);

    // ------------------------------------------------------------------
    // combinational observations
    // ------------------------------------------------------------------
    logic main_tick;
    logic slow_tick;
    logic main_good;
    logic slow_good;
    logic toggling;
    logic pll_locked;

    // edges only count while the oscillator is allowed to run
    assign main_tick  = main_osc_in & ~state_q.main_prev & ~stop_main_osc_in;
    assign slow_tick  = slow_osc_in & ~state_q.slow_prev & ~stop_slow_osc_in;
    // good drops combinationally with the stop request
    assign main_good  = (state_q.main_cnt == 14'h0000) & ~stop_main_osc_in;
    assign slow_good  = (state_q.slow_cnt == 6'h00) & ~stop_slow_osc_in;
    assign toggling   = (state_q.toggle_cnt != 16'h0000);
    assign pll_locked = (state_q.lock_cnt == LOCK_LAST);

    // inverting drive for a crystal; held off while stopped
    assign main_osc_out = ~main_osc_in & ~stop_main_osc_in;
    assign slow_osc_out = ~slow_osc_in & ~stop_slow_osc_in;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic       slow_is_osc;
        logic       pre_tick;
        logic       pll_tick;
        logic       src_tick;
        logic [8:0] acc_sum;
        logic [4:0] sys_r;
        logic [4:0] a1_r;
        logic [4:0] a2_r;
        logic       aux_run1;
        logic       aux_run2;
        state_d     = state_q;
        slow_is_osc = 1'b0;
        pre_tick    = 1'b0;
        pll_tick    = 1'b0;
        src_tick    = 1'b0;
        acc_sum     = 9'h000;
        sys_r       = 5'h00;
        a1_r        = 5'h00;
        a2_r        = 5'h00;
        aux_run1    = 1'b0;
        aux_run2    = 1'b0;

        state_d.main_prev = main_osc_in;
        state_d.slow_prev = slow_osc_in;

        // main countdown: two oscillator cycles per count, so 32766 to good
        if (stop_main_osc_in || !ext_reset_n_in) begin
            state_d.main_cnt  = CKGEN_MAIN_PRESET;
            state_d.main_half = 1'b0;
        end else if (main_tick && state_q.main_cnt != 14'h0000) begin
            state_d.main_half = ~state_q.main_half;
            if (state_q.main_half) begin
                state_d.main_cnt = state_q.main_cnt - 14'h0001;
            end
        end

        // slow countdown
        if (stop_slow_osc_in) begin
            state_d.slow_cnt = CKGEN_SLOW_PRESET;
        end else if (slow_tick && state_q.slow_cnt != 6'h00) begin
            state_d.slow_cnt = state_q.slow_cnt - 6'h01;
        end

        // activity detector: reloaded on every slow edge, drains otherwise
        if (slow_tick) begin
            state_d.toggle_cnt = TOGGLE_LAST;
        end else if (toggling) begin
            state_d.toggle_cnt = state_q.toggle_cnt - 16'h0001;
        end

        // slow source: oscillator only when selected, good and toggling
        slow_is_osc = state_q.ctrl[CKGEN_CTRL_SLOW_SEL] & slow_good & toggling;

        // prescaler: fixed halving then 8-bit divider, stopped when unused
        if (slow_is_osc) begin
            state_d.pre_half = 1'b0;
            state_d.pre_cnt  = 8'h00;
        end else if (main_tick) begin
            state_d.pre_half = ~state_q.pre_half;
            if (state_q.pre_half) begin
                if (state_q.pre_cnt >= state_q.slpre) begin
                    state_d.pre_cnt = 8'h00;
                    pre_tick        = 1'b1;
                end else begin
                    state_d.pre_cnt = state_q.pre_cnt + 8'h01;
                end
            end
        end
        // switching between whole pulses of either source cannot truncate one
        state_d.slow_en = slow_is_osc ? slow_tick : pre_tick;

        // pll lock timer runs while powered and the main clock is good
        if (state_q.ctrl[CKGEN_CTRL_PLL_PD] || !main_good) begin
            state_d.lock_cnt = 16'h0000;
        end else if (!pll_locked) begin
            state_d.lock_cnt = state_q.lock_cnt + 16'h0001;
        end

        // pll output as a rate accumulator at multiplier times main rate
        if (pll_locked) begin
            acc_sum = {1'b0, state_q.pll_acc}
                    + 9'(MAIN_STEP * ckgen_mul(state_q.hfpre[CKGEN_HF_MODE_LSB +: 2]));
            if (acc_sum >= {1'b0, CLK_STEP}) begin
                pll_tick        = 1'b1;
                state_d.pll_acc = 8'(acc_sum - {1'b0, CLK_STEP});
            end else begin
                state_d.pll_acc = acc_sum[7:0];
            end
        end else begin
            state_d.pll_acc = 8'h00;
        end

        // auxiliary clocks, each optionally immune to suspend
        aux_run1 = ~sys_suspend_in | state_q.ctrl[CKGEN_CTRL_AUX1_EN];
        aux_run2 = ~sys_suspend_in | state_q.ctrl[CKGEN_CTRL_AUX2_EN];
        a1_r = ckgen_div(state_q.aux1_cnt, state_q.auxpre[3:0], main_tick);
        a2_r = ckgen_div(state_q.aux2_cnt, state_q.auxpre[CKGEN_AUX2_LSB +: 4], main_tick);
        state_d.aux1_cnt = a1_r[3:0];
        state_d.aux2_cnt = a2_r[3:0];
        state_d.aux1_en  = a1_r[4] & aux_run1;
        state_d.aux2_en  = a2_r[4] & aux_run2;

        state_d.main_en = main_tick;
        state_d.pll_en  = pll_tick;

        // register writes
        if (wr_in) begin
            unique case (addr_in)
                CKGEN_OFF_CTRL: begin
                    state_d.ctrl = {2'b00, wdata_in[5:0]};
                    // zero only taken once the pll has settled
                    if (wdata_in[CKGEN_CTRL_HF_SEL]) begin
                        state_d.high_freq_clock_select = 1'b1;
                    end else if (pll_locked && !wdata_in[CKGEN_CTRL_PLL_PD]) begin
                        state_d.high_freq_clock_select = 1'b0;
                    end
                end
                CKGEN_OFF_HFPRE:  state_d.hfpre  = {2'b00, wdata_in[5:0]};
                CKGEN_OFF_SLPRE:  state_d.slpre  = wdata_in;
                CKGEN_OFF_AUXPRE: state_d.auxpre = wdata_in;
                default: ;
            endcase
        end
        if (state_d.ctrl[CKGEN_CTRL_PLL_PD] || !pll_locked) begin // no pll: main clock
            state_d.high_freq_clock_select = 1'b1;
        end

        // system source and divider; divider restarts on any source change
        src_tick = state_q.high_freq_clock_select ? main_tick : pll_tick;
        sys_r    = ckgen_div(state_q.sys_cnt, state_q.hfpre[CKGEN_HF_DIV_LSB +: 4], src_tick);
        if (state_d.high_freq_clock_select != state_q.high_freq_clock_select) begin
            state_d.sys_cnt = 4'h0;
            state_d.sys_en  = 1'b0;
        end else begin
            state_d.sys_cnt = sys_r[3:0];
            state_d.sys_en  = sys_r[4] & ~sys_suspend_in;
        end

        // register reads: data valid in the following cycle only
        state_d.rdata = 8'h00;
        if (rd_in) begin
            unique case (addr_in)
                CKGEN_OFF_CTRL: begin
                    state_d.rdata = state_q.ctrl;
                    state_d.rdata[CKGEN_CTRL_HF_SEL] = state_q.high_freq_clock_select;
                end
                CKGEN_OFF_HFPRE:  state_d.rdata = state_q.hfpre;
                CKGEN_OFF_SLPRE:  state_d.rdata = state_q.slpre;
                CKGEN_OFF_AUXPRE: state_d.rdata = state_q.auxpre;
                default:          state_d.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q            <= '0;
            state_q.main_cnt   <= CKGEN_MAIN_PRESET;
            state_q.slow_cnt   <= CKGEN_SLOW_PRESET;
            state_q.high_freq_clock_select       <= 1'b1;
            state_q.ctrl       <= CKGEN_CTRL_RESET;
            state_q.hfpre      <= CKGEN_HF_RESET;
            state_q.slpre      <= CKGEN_SL_RESET;
            state_q.auxpre     <= CKGEN_AUX_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_out       = state_q.rdata;
    assign main_clk_en_out = state_q.main_en;
    assign slow_clk_en_out = state_q.slow_en;
    assign pll_clk_en_out  = state_q.pll_en;
    assign sys_clk_en_out  = state_q.sys_en;
    assign aux1_clk_en_out = state_q.aux1_en;
    assign aux2_clk_en_out = state_q.aux2_en;
    assign main_good_out   = main_good;
    assign slow_good_out   = slow_good;
    // held until countdown done and external reset released
    assign int_reset_out   = ~main_good | ~ext_reset_n_in;

endmodule : ckgen_top

// [rtl/ckgen_pkg.sv]
// clock generation and oscillator control: shared constants
// assumes a single 100 MHz system clock; all derived clocks are enable pulses
package ckgen_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets within the clock and reset block)
    // ------------------------------------------------------------------
    localparam logic [7:0] CKGEN_OFF_CTRL    = 8'h40; // clock_reset_control
    localparam logic [7:0] CKGEN_OFF_HFPRE   = 8'h42; // high_freq_prescaler
    localparam logic [7:0] CKGEN_OFF_SLPRE   = 8'h44; // slow clock prescaler
    localparam logic [7:0] CKGEN_OFF_AUXPRE  = 8'h46; // auxiliary prescaler

    // ------------------------------------------------------------------
    // clock_reset_control fields
    // ------------------------------------------------------------------
    localparam int CKGEN_CTRL_SLOW_SEL = 0;
    localparam int CKGEN_CTRL_HF_SEL   = 1; // high_freq_clock_select
    localparam int CKGEN_CTRL_PLL_PD   = 2; // pll_power_down
    localparam int CKGEN_CTRL_AUX1_EN  = 3;
    localparam int CKGEN_CTRL_AUX2_EN  = 4;
    localparam int CKGEN_CTRL_POR      = 5;
    localparam logic [7:0] CKGEN_CTRL_RESET = 8'h26; // por, pll off, main clock

    // ------------------------------------------------------------------
    // high_freq_prescaler fields: [3:0] divisor-1, [5:4] pll multiplier
    // ------------------------------------------------------------------
    localparam int CKGEN_HF_DIV_LSB  = 0;
    localparam int CKGEN_HF_MODE_LSB = 4;
    localparam logic [7:0] CKGEN_HF_RESET  = 8'h00;
    localparam logic [7:0] CKGEN_SL_RESET  = 8'hff; // slowest prescaled clock
    localparam logic [7:0] CKGEN_AUX_RESET = 8'h00;
    localparam int CKGEN_AUX2_LSB = 4;

    // pll multiplier codes
    localparam logic [1:0] CKGEN_MODE_X3 = 2'h0;
    localparam logic [1:0] CKGEN_MODE_X4 = 2'h1;
    localparam logic [7:0] CKGEN_MUL3    = 8'h03;
    localparam logic [7:0] CKGEN_MUL4    = 8'h04;
    localparam logic [7:0] CKGEN_MUL5    = 8'h05;

    // ------------------------------------------------------------------
    // stability countdowns
    // ------------------------------------------------------------------
    localparam logic [13:0] CKGEN_MAIN_PRESET = 14'h3fff;
    localparam logic [5:0]  CKGEN_SLOW_PRESET = 6'h3f;

    // ------------------------------------------------------------------
    // rates and times
    // ------------------------------------------------------------------
    localparam int CKGEN_CLK_MHZ  = 100;
    localparam int CKGEN_MAIN_MHZ = 12;
    localparam int CKGEN_PLL_LOCK_US = 100;  // pll settling time
    localparam int CKGEN_TOGGLE_NS   = 61036; // two slow oscillator periods
    // longest wait rounds down, least time rounds up
    localparam int CKGEN_PLL_LOCK_CYC = CKGEN_PLL_LOCK_US * CKGEN_CLK_MHZ;
    localparam int CKGEN_TOGGLE_CYC   = (CKGEN_TOGGLE_NS * CKGEN_CLK_MHZ) / 1000;

endpackage : ckgen_pkg

// [tb/ckgen_osc_model.sv]
// oscillator and power-management side of ckgen_top
// assumes clock_in is the bench system clock; pins change after its edge
`timescale 1ns/10ps
module ckgen_osc_model #(
    parameter int SLOW_HALF = 20
) (
    // system clock
    input  wire logic clock_in,
    // stop requests and slow crystal presence
    input  wire logic stop_main_osc_in,
    input  wire logic stop_slow_osc_in,
    input  wire logic slow_run_in,
    // oscillator levels into the device
    output logic      main_osc_out,
    output logic      slow_osc_out
);
    // ----------------------------------------------------------
    // oscillators
    // ----------------------------------------------------------
    int slow_cnt = 0;
    initial begin
        main_osc_out = 1'b0;
        slow_osc_out = 1'b0;
    end
    // main input toggles every clock: a fast external clock keeps start-up short
    always @(posedge clock_in) begin
        main_osc_out <= stop_main_osc_in ? 1'b0 : ~main_osc_out;
        if (stop_slow_osc_in || !slow_run_in) begin
            slow_cnt     <= 0;
            slow_osc_out <= 1'b0;
        end else if (slow_cnt == SLOW_HALF - 1) begin
            slow_cnt     <= 0;
            slow_osc_out <= ~slow_osc_out;
        end else begin
            slow_cnt <= slow_cnt + 1;
        end
    end
endmodule : ckgen_osc_model

// [tb/ckgen_top_properties.sv]
// port-level assertions for ckgen_top, bound into every instance
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/10ps
module ckgen_props (
    // clock and reset
    input wire logic       clock_in,
    input wire logic       rst_in,
    // read port
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // requests and oscillator input
    input wire logic       stop_main_osc_in,
    input wire logic       stop_slow_osc_in,
    input wire logic       sys_suspend_in,
    input wire logic       ext_reset_n_in,
    input wire logic       main_osc_in,
    // outputs under check
    input wire logic       main_clk_en_out,
    input wire logic       sys_clk_en_out,
    input wire logic       main_good_out,
    input wire logic       slow_good_out,
    input wire logic       int_reset_out
);
    // ----------------------------------------------------------
    // start-up tick counter and assertions
    // ----------------------------------------------------------
    logic        osc_q;
    logic [16:0] tick_q;
    // main rising edges since the countdown was last preset, saturating
    always_ff @(posedge clock_in) begin
        osc_q <= main_osc_in;
        if (rst_in || stop_main_osc_in || !ext_reset_n_in) begin
            tick_q <= '0;
        end else if (main_osc_in && !osc_q && !tick_q[16]) begin
            tick_q <= tick_q + 17'd1;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    main_good_drop_a: assert property (stop_main_osc_in |-> !main_good_out)
        else $error("main good high during stop");
    slow_good_drop_a: assert property (stop_slow_osc_in |-> !slow_good_out)
        else $error("slow good high during stop");
    main_good_time_a: assert property ($rose(main_good_out) |-> tick_q inside {[32764:32772]})
        else $error("main good after wrong tick count");
    main_good_hold_a: assert property (main_good_out && ext_reset_n_in |=> main_good_out || stop_main_osc_in)
        else $error("main good dropped without cause");
    int_reset_hold_a: assert property (!main_good_out || !ext_reset_n_in |-> int_reset_out)
        else $error("internal reset released early");
    int_reset_end_a: assert property (main_good_out && ext_reset_n_in |-> !int_reset_out)
        else $error("internal reset stuck");
    tick_enable_a: assert property ($rose(main_osc_in) && !stop_main_osc_in && !$past(rst_in) |=> main_clk_en_out)
        else $error("main tick without enable");
    enable_cause_a: assert property (main_clk_en_out |-> $past(main_osc_in) && !$past(main_osc_in, 2))
        else $error("main enable without tick");
    suspend_sys_a: assert property (sys_suspend_in && $past(sys_suspend_in) |-> !sys_clk_en_out)
        else $error("system enable during suspend");
    read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside read cycle");
endmodule : ckgen_props

bind ckgen_top ckgen_props ckgen_props_i (
    .clock_in(clock_in), .rst_in(rst_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .stop_main_osc_in(stop_main_osc_in), .stop_slow_osc_in(stop_slow_osc_in),
    .sys_suspend_in(sys_suspend_in), .ext_reset_n_in(ext_reset_n_in),
    .main_osc_in(main_osc_in), .main_clk_en_out(main_clk_en_out),
    .sys_clk_en_out(sys_clk_en_out), .main_good_out(main_good_out),
    .slow_good_out(slow_good_out), .int_reset_out(int_reset_out));

// [tb/ckgen_top_tb_top.sv]
// self-checking bench for ckgen_top: registers, countdowns, dividers, pll
// assumes ckgen_osc_model toggles the main input on every rising clock edge
`timescale 1ns/10ps
module ckgen_top_tb_top;
    import ckgen_pkg::*;
    // ----------------------------------------------------------
    // stimulus, observation and scenarios
    // ----------------------------------------------------------
    localparam int SLOW_HALF = 20;
    logic       clock_in  = 1'b0;
    logic       rst_in    = 1'b1;
    logic       wr_in     = 1'b0;
    logic       rd_in     = 1'b0;
    logic       stop_main = 1'b0;
    logic       stop_slow = 1'b0;
    logic       suspend   = 1'b0;
    logic       ext_n     = 1'b1;
    logic       slow_run  = 1'b0;
    logic [7:0] addr_in   = 8'h00;
    logic [7:0] wdata_in  = 8'h00;
    logic [7:0] rdata;
    logic       mosc, mdrv, sosc, sdrv, men, sen, pen, syen, a1, a2, mgood, sgood, ires;
    int         n_errors   = 0;
    int         num_checks = 0;
    time        t0;

    ckgen_top #(.PLL_LOCK_CYC(16), .TOGGLE_CYC(64)) ckgen_top_i (
        .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .stop_main_osc_in(stop_main),
        .stop_slow_osc_in(stop_slow), .sys_suspend_in(suspend), .ext_reset_n_in(ext_n),
        .main_osc_in(mosc), .main_osc_out(mdrv), .slow_osc_in(sosc), .slow_osc_out(sdrv),
        .main_clk_en_out(men), .slow_clk_en_out(sen), .pll_clk_en_out(pen),
        .sys_clk_en_out(syen), .aux1_clk_en_out(a1), .aux2_clk_en_out(a2),
        .main_good_out(mgood), .slow_good_out(sgood), .int_reset_out(ires));
    ckgen_osc_model #(.SLOW_HALF(SLOW_HALF)) ckgen_osc_model_i (
        .clock_in(clock_in), .stop_main_osc_in(stop_main), .stop_slow_osc_in(stop_slow),
        .slow_run_in(slow_run), .main_osc_out(mosc), .slow_osc_out(sosc));

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    // tolerance only for counts the bench computes itself
    task automatic check(input logic [31:0] got, exp, input int tol = 0);
        num_checks++;
        if (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp)) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in    <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in   <= 1'b0;
        #1 d = rdata;
    endtask : rd

    function automatic logic sig(input int w);
        case (w)
            0: return sen;
            1: return syen;
            2: return a1;
            3: return a2;
            4: return pen;
            5: return mgood;
            6: return sgood;
            default: return men;
        endcase
    endfunction : sig

    // interval between the 2nd and 3rd pulse, skipping any stale first period
    task automatic gap(input int w, output int g);
        int s, k;
        k = 0;
        for (int t = 0; t < 4000 && k < 3; t++) begin
            @(posedge clock_in);
            #1;
            if (sig(w) === 1'b1) begin
                k++;
                g = t - s;
                s = t;
            end
        end
        if (k < 3) begin
            n_errors++;
            print_verdict();
        end
        @(posedge clock_in);
    endtask : gap

    task automatic cnt(input int w, n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clock_in);
            #1;
            if (sig(w) === 1'b1) c++;
        end
        @(posedge clock_in);
    endtask : cnt

    task automatic wait_hi(input int w, output int t);
        for (t = 0; sig(w) !== 1'b1; t++) begin
            @(posedge clock_in);
            #1;
            if (t > 80000) begin
                n_errors++;
                print_verdict();
            end
        end
        @(posedge clock_in);
    endtask : wait_hi

    task automatic t_reset();
        logic [7:0] a[5] = '{CKGEN_OFF_CTRL, CKGEN_OFF_HFPRE, CKGEN_OFF_SLPRE,
                             CKGEN_OFF_AUXPRE, 8'h48};
        logic [7:0] e[5] = '{CKGEN_CTRL_RESET, CKGEN_HF_RESET, CKGEN_SL_RESET,
                             CKGEN_AUX_RESET, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            rd(a[i], d);
            check(d, e[i]);
        end
        check(ires, 1);
        #10 check(rdata, 0);
    endtask : t_reset

    task automatic t_main_start();
        int t;
        wait_hi(5, t);
        check(($time - t0) / 10, 65536, 8);
        check(ires, 0);
    endtask : t_main_start

    task automatic t_slow_pre();
        int g;
        wr(CKGEN_OFF_SLPRE, 8'h00);
        gap(0, g);
        check(g, 4);
        wr(CKGEN_OFF_SLPRE, 8'hff);
        gap(0, g);
        check(g, 1024);
    endtask : t_slow_pre

    task automatic t_sys_div();
        int g;
        wr(CKGEN_OFF_HFPRE, 8'h0f);
        gap(1, g);
        check(g, 32);
        wr(CKGEN_OFF_HFPRE, 8'h00);
        gap(1, g);
        check(g, 2);
    endtask : t_sys_div

    task automatic t_pll();
        logic [7:0] d;
        int c;
        for (int m = 0; m < 3; m++) begin
            wr(CKGEN_OFF_CTRL, 8'h26);
            wr(CKGEN_OFF_HFPRE, 8'(m) << CKGEN_HF_MODE_LSB);
            wr(CKGEN_OFF_CTRL, 8'h22);
            wr(CKGEN_OFF_CTRL, 8'h20);
            rd(CKGEN_OFF_CTRL, d);
            check(d[1], 1);
            repeat (40) @(posedge clock_in);
            wr(CKGEN_OFF_CTRL, 8'h20);
            rd(CKGEN_OFF_CTRL, d);
            check(d[1], 0);
            cnt(4, 1000, c);
            check(c, 120 * (m + 3), 2);
            cnt(1, 1000, c);
            check(c, 120 * (m + 3), 2);
        end
        wr(CKGEN_OFF_CTRL, 8'h22);
        cnt(1, 100, c);
        check(c, 50, 1);
    endtask : t_pll

    task automatic t_aux();
        int c;
        wr(CKGEN_OFF_AUXPRE, 8'h31);
        gap(2, c);
        check(c, 4);
        gap(3, c);
        check(c, 8);
        wr(CKGEN_OFF_CTRL, 8'h2e);
        suspend <= 1'b1;
        cnt(2, 100, c);
        check(c, 25, 1);
        cnt(3, 100, c);
        check(c, 0);
        cnt(1, 100, c);
        check(c, 0);
        suspend <= 1'b0;
    endtask : t_aux

    // slow crystal absent first, so the selection must not take
    task automatic t_slow_osc();
        int g;
        wr(CKGEN_OFF_CTRL, 8'h23);
        gap(0, g);
        check(g, 1024);
        slow_run <= 1'b1;
        wait_hi(6, g);
        check(g, 125 * SLOW_HALF, 2);
        gap(0, g);
        check(g, 2 * SLOW_HALF);
        stop_slow <= 1'b1;
        #1 check(sgood, 0);
        check(sdrv, 0);
        gap(0, g);
        check(g, 1024);
    endtask : t_slow_osc

    task automatic t_ext_stop();
        int c;
        ext_n <= 1'b0;
        #1 check(ires, 1);
        repeat (2) @(posedge clock_in);
        ext_n <= 1'b1;
        repeat (200) @(posedge clock_in);
        #1 check(ires, 1);
        check(mdrv, !mosc);
        @(posedge clock_in);
        stop_main <= 1'b1;
        #1 check(mdrv, 0);
        cnt(7, 100, c);
        check(c, 0);
    endtask : t_ext_stop

    initial begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        t0 = $time;
        t_reset();
        t_main_start();
        t_slow_pre();
        t_sys_div();
        t_pll();
        t_aux();
        t_slow_osc();
        t_ext_stop();
        print_verdict();
    end
endmodule : ckgen_top_tb_top
